// ==== design/nvhb_top.sv ====
// Network variable heartbeat, send limiting, clock sync and node control logic
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module nvhb_top #(
  parameter int unsigned TICK_CYCLES = nvhb_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                                         sys_clk_i,
  input  wire logic                                         rst_n_i,
  input  wire nvhb_pkg::nvhb_bus_req_t                      bus_i,
  output logic      [nvhb_pkg::DATA_W-1:0]                  rdata_o,
  input  wire logic [nvhb_pkg::NODE_W-1:0]                  node_addr_i,
  input  wire nvhb_pkg::nvhb_nv_upd_t [nvhb_pkg::N_IN-1:0]  in_upd_i,
  input  wire logic                                         ts_wr_i,
  input  wire logic [nvhb_pkg::RTC_W-1:0]                   ts_value_i,
  input  wire logic                                         nreq_wr_i,
  input  wire logic [7:0]                                   nreq_value_i,
  input  wire logic [nvhb_pkg::N_OUT-1:0][nvhb_pkg::NV_W-1:0] out_value_i,
  output logic      [nvhb_pkg::N_IN-1:0][nvhb_pkg::NV_W-1:0]  in_value_o,
  output logic      [nvhb_pkg::N_IN-1:0]                    in_reliable_o,
  output logic      [nvhb_pkg::N_OUT-1:0]                   out_send_o,
  output logic      [nvhb_pkg::N_OUT-1:0][nvhb_pkg::NV_W-1:0] out_sent_value_o,
  output logic      [nvhb_pkg::RTC_W-1:0]                   rtc_o,
  output logic      [7:0]                                   node_status_o,
  output logic                                              irq_o
);
  import nvhb_pkg::*;

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0]        rst_sync_r;
  logic              rst_n;
  logic [NODE_W-1:0] node_s1_r;
  logic [NODE_W-1:0] node_s2_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      node_s1_r <= 8'h00;
      node_s2_r <= 8'h00;
    end else begin
      node_s1_r <= node_addr_i;
      node_s2_r <= node_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Second tick
  // ---------------------------------------------------------------
  logic tick;

  nvhb_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .tick_o    (tick)
  );

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  logic [SEC_W-1:0]  rcv_hb_r;
  logic [SEC_W-1:0]  send_hb_r;
  logic [SEC_W-1:0]  min_ana_r;
  logic [SEC_W-1:0]  min_dig_r;
  logic [N_OUT-1:0]  out_dig_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [CAL_AW-1:0] cal_addr_r;
  logic [NV_W-1:0]   cal_rdata;
  logic [DATA_W-1:0] rdata_r;
  logic [RTC_W-1:0]  rtc_r;
  logic [7:0]        nstat_r;
  logic [N_IN-1:0]   in_rel_r;

  wire sel    = (bus_i.node == node_s2_r);
  wire wr_en  = bus_i.wr & sel;
  wire rd_en  = bus_i.rd & sel;
  wire wr_rcv = wr_en & (bus_i.addr == A_RCV_HB);
  wire wr_shb = wr_en & (bus_i.addr == A_SEND_HB);
  wire wr_mna = wr_en & (bus_i.addr == A_MIN_ANA);
  wire wr_mnd = wr_en & (bus_i.addr == A_MIN_DIG);
  wire wr_dig = wr_en & (bus_i.addr == A_OUT_DIG);
  wire wr_rtc = wr_en & (bus_i.addr == A_RTC);
  wire wr_ist = wr_en & (bus_i.addr == A_IRQ_STAT);
  wire wr_imk = wr_en & (bus_i.addr == A_IRQ_MASK);
  wire wr_cad = wr_en & (bus_i.addr == A_CAL_ADDR);
  wire wr_cdt = wr_en & (bus_i.addr == A_CAL_DATA);

  wire [DATA_W-1:0] rd_mux =
    (bus_i.addr == A_RCV_HB)   ? {16'h0000, rcv_hb_r}                 :
    (bus_i.addr == A_SEND_HB)  ? {16'h0000, send_hb_r}                :
    (bus_i.addr == A_MIN_ANA)  ? {16'h0000, min_ana_r}                :
    (bus_i.addr == A_MIN_DIG)  ? {16'h0000, min_dig_r}                :
    (bus_i.addr == A_OUT_DIG)  ? {28'h0000000, out_dig_r}             :
    (bus_i.addr == A_RTC)      ? rtc_r                                :
    (bus_i.addr == A_NSTAT)    ? {24'h000000, nstat_r}                :
    (bus_i.addr == A_IRQ_STAT) ? {29'h00000000, irq_stat_r}           :
    (bus_i.addr == A_IRQ_MASK) ? {29'h00000000, irq_mask_r}           :
    (bus_i.addr == A_IN_REL)   ? {28'h0000000, in_rel_r}              :
    (bus_i.addr == A_CAL_ADDR) ? {28'h0000000, cal_addr_r}            :
    (bus_i.addr == A_CAL_DATA) ? {16'h0000, cal_rdata}                :
    (bus_i.addr == A_NODE)     ? {24'h000000, node_s2_r}              :
                                 32'h0000_0000;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rcv_hb_r   <= RST_SEC;
      send_hb_r  <= RST_SEC;
      min_ana_r  <= RST_SEC;
      min_dig_r  <= RST_SEC;
      out_dig_r  <= RST_OUT_DIG;
      irq_mask_r <= RST_IRQ;
      cal_addr_r <= 4'h0;
      rdata_r    <= 32'h0000_0000;
    end else begin
      if (wr_rcv) rcv_hb_r <= bus_i.wdata[SEC_W-1:0];
      if (wr_shb) send_hb_r <= bus_i.wdata[SEC_W-1:0];
      if (wr_mna) min_ana_r <= bus_i.wdata[SEC_W-1:0];
      if (wr_mnd) min_dig_r <= bus_i.wdata[SEC_W-1:0];
      if (wr_dig) out_dig_r <= bus_i.wdata[N_OUT-1:0];
      if (wr_imk) irq_mask_r <= bus_i.wdata[IRQ_W-1:0];
      if (wr_cad) cal_addr_r <= bus_i.wdata[CAL_AW-1:0];
      rdata_r <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // Read data shows the word at CAL_ADDR one cycle after the address settles
  nvhb_calmem u_calmem (
    .sys_clk_i (sys_clk_i),
    .we_i      (wr_cdt),
    .addr_i    (cal_addr_r),
    .wdata_i   (bus_i.wdata[NV_W-1:0]),
    .rdata_o   (cal_rdata)
  );

  // ---------------------------------------------------------------
  // Input variables: receive supervision
  // ---------------------------------------------------------------
  wire             rcv_on = (rcv_hb_r != RST_SEC);
  logic [N_IN-1:0] to_hit;
  logic [N_IN-1:0] unrel;

  generate
    for (genvar i = 0; i < N_IN; i++) begin : g_in
      logic [NV_W-1:0]  hold_r;
      logic             rng_r;
      logic [SEC_W-1:0] age_r;
      logic             unrel_r;
      wire  [SEC_W-1:0] age_inc = (age_r == 16'hFFFF) ? age_r : SEC_W'(age_r + 16'h0001);

      assign to_hit[i] = tick & rcv_on & ~in_upd_i[i].upd & ~unrel_r & (age_inc >= rcv_hb_r);
      assign unrel[i]  = unrel_r & rcv_on;

      always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          hold_r      <= RST_NV;
          rng_r       <= 1'b0;
          age_r       <= RST_SEC;
          unrel_r     <= 1'b0;
          in_rel_r[i] <= 1'b0;
        end else begin
          if (in_upd_i[i].upd) begin
            hold_r  <= in_upd_i[i].value;
            rng_r   <= in_upd_i[i].in_range;
            age_r   <= RST_SEC;
            unrel_r <= 1'b0;
          end else if (tick) begin
            age_r <= age_inc;
            if (to_hit[i]) unrel_r <= 1'b1;
          end
          in_rel_r[i] <= rng_r & ~unrel[i];
        end
      end
      assign in_value_o[i] = hold_r;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Node control
  // ---------------------------------------------------------------
  nvhb_state_t state_r;
  nvhb_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (nreq_wr_i) begin
      case (nreq_value_i)
        NREQ_DISABLE: state_nxt = NVHB_ST_OFFLINE;
        NREQ_ENABLE:  state_nxt = NVHB_ST_ONLINE;
        NREQ_NORMAL:  state_nxt = state_r;
        default:      state_nxt = state_r;
      endcase
    end
  end

  wire online = (state_r == NVHB_ST_ONLINE);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= NVHB_ST_ONLINE;
      nstat_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      nstat_r <= {6'h00, |unrel, state_nxt == NVHB_ST_OFFLINE};
    end
  end

  // ---------------------------------------------------------------
  // Output variables: change, heartbeat and minimum send time
  // ---------------------------------------------------------------
  wire shb_on = (send_hb_r != RST_SEC);

  generate
    for (genvar j = 0; j < N_OUT; j++) begin : g_out
      logic [NV_W-1:0]  sent_r;
      logic [SEC_W-1:0] age_r;
      logic             send_r;
      wire  [SEC_W-1:0] min_t   = out_dig_r[j] ? min_dig_r : min_ana_r;
      wire              changed = (out_value_i[j] != sent_r);
      wire              hb_due  = shb_on & (age_r >= send_hb_r);
      wire              min_ok  = (age_r >= min_t);
      wire              fire    = online & min_ok & (changed | hb_due);

      always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          sent_r <= RST_NV;
          age_r  <= RST_SEC;
          send_r <= 1'b0;
        end else begin
          send_r <= fire;
          if (fire) begin
            sent_r <= out_value_i[j];
            age_r  <= RST_SEC;
          end else if (tick && age_r != 16'hFFFF) begin
            age_r <= SEC_W'(age_r + 16'h0001);
          end
        end
      end
      assign out_send_o[j]       = send_r;
      assign out_sent_value_o[j] = sent_r;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Real-time clock
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rtc_r <= RST_RTC;
    end else if (ts_wr_i) begin
      rtc_r <= ts_value_i;
    end else if (wr_rtc) begin
      rtc_r <= bus_i.wdata;
    end else if (tick) begin
      rtc_r <= rtc_r + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic             irq_r;

  assign irq_set[IRQ_TIMEOUT] = |to_hit;
  assign irq_set[IRQ_TSYNC]   = ts_wr_i;
  assign irq_set[IRQ_NREQ]    = nreq_wr_i;

  // Set beats a same-cycle write-one clear
  wire [IRQ_W-1:0] irq_clr      = wr_ist ? bus_i.wdata[IRQ_W-1:0] : RST_IRQ;
  wire [IRQ_W-1:0] irq_stat_nxt = irq_set | (irq_stat_r & ~irq_clr);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= RST_IRQ;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign rdata_o       = rdata_r;
  assign in_reliable_o = in_rel_r;
  assign rtc_o         = rtc_r;
  assign node_status_o = nstat_r;
  assign irq_o         = irq_r;
endmodule // nvhb_top

// ==== pkg/nvhb_pkg.sv ====
// Shared constants, types and register map of the network variable heartbeat timer
package nvhb_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int N_IN      = 4;
  localparam int N_OUT     = 4;
  localparam int NV_W      = 16;
  localparam int SEC_W     = 16;
  localparam int RTC_W     = 32;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int NODE_W    = 8;
  localparam int CAL_AW    = 4;
  localparam int CAL_DEPTH = 16;
  localparam int IRQ_W     = 3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_PERIOD_S   = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_RCV_HB   = 8'h00;
  localparam logic [ADDR_W-1:0] A_SEND_HB  = 8'h04;
  localparam logic [ADDR_W-1:0] A_MIN_ANA  = 8'h08;
  localparam logic [ADDR_W-1:0] A_MIN_DIG  = 8'h0C;
  localparam logic [ADDR_W-1:0] A_OUT_DIG  = 8'h10;
  localparam logic [ADDR_W-1:0] A_RTC      = 8'h14;
  localparam logic [ADDR_W-1:0] A_NSTAT    = 8'h18;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h1C;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h20;
  localparam logic [ADDR_W-1:0] A_IN_REL   = 8'h24;
  localparam logic [ADDR_W-1:0] A_CAL_ADDR = 8'h28;
  localparam logic [ADDR_W-1:0] A_CAL_DATA = 8'h2C;
  localparam logic [ADDR_W-1:0] A_NODE     = 8'h30;

  // ---------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------
  localparam logic [SEC_W-1:0]  RST_SEC     = 16'h0000;
  localparam logic [N_OUT-1:0]  RST_OUT_DIG = 4'h0;
  localparam logic [RTC_W-1:0]  RST_RTC     = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]  RST_IRQ     = 3'h0;
  localparam logic [NV_W-1:0]   RST_NV      = 16'h0000;
  localparam int IRQ_TIMEOUT  = 0;
  localparam int IRQ_TSYNC    = 1;
  localparam int IRQ_NREQ     = 2;
  localparam int NST_OFFLINE  = 0;
  localparam int NST_UNREL    = 1;

  // Node request commands
  localparam logic [7:0] NREQ_NORMAL  = 8'h00;
  localparam logic [7:0] NREQ_DISABLE = 8'h01;
  localparam logic [7:0] NREQ_ENABLE  = 8'h02;

  typedef enum logic [0:0] {
    NVHB_ST_ONLINE  = 1'b0,
    NVHB_ST_OFFLINE = 1'b1
  } nvhb_state_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [NODE_W-1:0] node;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvhb_bus_req_t;

  typedef struct packed {
    logic            upd;
    logic            in_range;
    logic [NV_W-1:0] value;
  } nvhb_nv_upd_t;

endpackage

// ==== design/nvhb_tick.sv ====
// One-second tick divider
`timescale 1ns/1ps
module nvhb_tick #(
  parameter int unsigned TICK_CYCLES = nvhb_pkg::TICK_CYCLES_DEF
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  import nvhb_pkg::*;

  logic [31:0] cnt_r;
  logic        tick_r;
  wire         wrap = (cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
      tick_r <= wrap;
    end
  end

  assign tick_o = tick_r;
endmodule // nvhb_tick

// ==== design/nvhb_calmem.sv ====
// Calibration value store with registered read port
`timescale 1ns/1ps
module nvhb_calmem (
  input  wire logic                        sys_clk_i,
  input  wire logic                        we_i,
  input  wire logic [nvhb_pkg::CAL_AW-1:0] addr_i,
  input  wire logic [nvhb_pkg::NV_W-1:0]   wdata_i,
  output logic      [nvhb_pkg::NV_W-1:0]   rdata_o
);
  import nvhb_pkg::*;

  // No reset on the array: contents outlive a logic reset
  logic [NV_W-1:0] mem_r [CAL_DEPTH];
  logic [NV_W-1:0] rdata_r;

  always_ff @(posedge sys_clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    rdata_r <= mem_r[addr_i];
  end

  assign rdata_o = rdata_r;
endmodule // nvhb_calmem

// ==== verification/nvhb_monitor.sv ====
// Concurrent checks on the heartbeat timer's ports
`timescale 1ns/1ps
module nvhb_monitor (
  input wire logic                                           sys_clk_i,
  input wire logic                                           rst_n_i,
  input wire nvhb_pkg::nvhb_bus_req_t                        bus_i,
  input wire logic [nvhb_pkg::DATA_W-1:0]                    rdata_o,
  input wire logic [nvhb_pkg::NODE_W-1:0]                    node_addr_i,
  input wire nvhb_pkg::nvhb_nv_upd_t [nvhb_pkg::N_IN-1:0]    in_upd_i,
  input wire logic [nvhb_pkg::N_IN-1:0][nvhb_pkg::NV_W-1:0]  in_value_o,
  input wire logic [nvhb_pkg::N_IN-1:0]                      in_reliable_o,
  input wire logic                                           ts_wr_i,
  input wire logic [nvhb_pkg::RTC_W-1:0]                     ts_value_i,
  input wire logic [nvhb_pkg::RTC_W-1:0]                     rtc_o,
  input wire logic                                           nreq_wr_i,
  input wire logic [7:0]                                     nreq_value_i,
  input wire logic [7:0]                                     node_status_o,
  input wire logic [nvhb_pkg::N_OUT-1:0][nvhb_pkg::NV_W-1:0] out_value_i,
  input wire logic [nvhb_pkg::N_OUT-1:0]                     out_send_o,
  input wire logic [nvhb_pkg::N_OUT-1:0][nvhb_pkg::NV_W-1:0] out_sent_value_o
);
  import nvhb_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  chk_upd_value: assert property (in_upd_i[0].upd |=> in_value_o[0] == $past(in_upd_i[0].value))
    else $error("input value not captured");
  // Second update inside the window would restart the result
  chk_upd_reliable: assert property (in_upd_i[0].upd ##1 !in_upd_i[0].upd
    |=> in_reliable_o[0] == $past(in_upd_i[0].in_range, 2)) else $error("reliable flag wrong after update");
  chk_ts_load: assert property (ts_wr_i |=> rtc_o == $past(ts_value_i))
    else $error("clock not loaded by time sync");
  chk_sent_value: assert property (out_send_o[0] |-> out_sent_value_o[0] == $past(out_value_i[0]))
    else $error("sent value differs from output value");
  chk_offline_quiet: assert property (node_status_o[NST_OFFLINE] && $past(node_status_o[NST_OFFLINE])
    && $past(node_status_o[NST_OFFLINE], 2) |-> out_send_o == '0) else $error("send while offline");
  chk_nreq_disable: assert property (nreq_wr_i && nreq_value_i == NREQ_DISABLE
    |=> node_status_o[NST_OFFLINE]) else $error("disable request not reported");
  chk_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
    else $error("read data outside read answer");
  chk_wrong_node: assert property (bus_i.rd && bus_i.node != node_addr_i |=> rdata_o == '0)
    else $error("answer at foreign node address");
endmodule // nvhb_monitor

bind nvhb_top nvhb_monitor u_mon (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .node_addr_i(node_addr_i),
  .in_upd_i(in_upd_i), .in_value_o(in_value_o), .in_reliable_o(in_reliable_o), .ts_wr_i(ts_wr_i),
  .ts_value_i(ts_value_i), .rtc_o(rtc_o), .nreq_wr_i(nreq_wr_i), .nreq_value_i(nreq_value_i),
  .node_status_o(node_status_o), .out_value_i(out_value_i), .out_send_o(out_send_o),
  .out_sent_value_o(out_sent_value_o));

// ==== verification/nvhb_peer.sv ====
// Network peer model: bound sources, supervisor clock and node tool
`timescale 1ns/1ps
module nvhb_peer (
  input  wire logic                                        sys_clk_i,
  output nvhb_pkg::nvhb_nv_upd_t [nvhb_pkg::N_IN-1:0]      upd_o,
  output logic                                             ts_wr_o,
  output logic [nvhb_pkg::RTC_W-1:0]                       ts_o,
  output logic                                             nreq_wr_o,
  output logic [7:0]                                       nreq_o
);
  import nvhb_pkg::*;
  initial begin
    upd_o = '0;
    ts_wr_o = 1'b0;
    ts_o = '0;
    nreq_wr_o = 1'b0;
    nreq_o = '0;
  end
  task src_upd(input int i, input logic [NV_W-1:0] v, input logic r);
    @(posedge sys_clk_i);
    upd_o[i] <= {1'b1, r, v};
    @(posedge sys_clk_i);
    upd_o[i].upd <= 1'b0;
  endtask
  // Daily cadence compressed; only the write itself matters here
  task time_sync(input logic [RTC_W-1:0] v);
    @(posedge sys_clk_i);
    ts_wr_o <= 1'b1;
    ts_o <= v;
    @(posedge sys_clk_i);
    ts_wr_o <= 1'b0;
  endtask
  task node_req(input logic [7:0] c);
    @(posedge sys_clk_i);
    nreq_wr_o <= 1'b1;
    nreq_o <= c;
    @(posedge sys_clk_i);
    nreq_wr_o <= 1'b0;
  endtask
endmodule // nvhb_peer

// ==== verification/tb_top.sv ====
// Self-checking bench for the heartbeat timer
`timescale 1ns/1ps
module tb_top;
  import nvhb_pkg::*;
  localparam logic [7:0] RW [4] = '{A_RCV_HB, A_SEND_HB, A_MIN_ANA, A_MIN_DIG};
  localparam logic [7:0] CODES [4] = '{NREQ_DISABLE, 8'h05, NREQ_NORMAL, NREQ_ENABLE};
  logic clk, rst_n, ts_wr, nreq_wr, irq, off_m;
  nvhb_bus_req_t bus;
  nvhb_nv_upd_t [N_IN-1:0] upd;
  logic [DATA_W-1:0] rdata, t;
  logic [NODE_W-1:0] node;
  logic [RTC_W-1:0] ts_v, rtc;
  logic [7:0] nreq_v, nst;
  logic [N_OUT-1:0][NV_W-1:0] ov, sv;
  logic [N_IN-1:0][NV_W-1:0] iv;
  logic [N_IN-1:0] rel;
  logic [N_OUT-1:0] snd;
  logic [NV_W-1:0] v, cv [2];
  logic [31:0] mdl [logic [7:0]];
  int err_count, n_tests, seed, n, sc [N_OUT];

  nvhb_top #(.TICK_CYCLES(10)) dut (.sys_clk_i(clk), .rst_n_i(rst_n), .bus_i(bus), .rdata_o(rdata),
    .node_addr_i(node), .in_upd_i(upd), .ts_wr_i(ts_wr), .ts_value_i(ts_v), .nreq_wr_i(nreq_wr),
    .nreq_value_i(nreq_v), .out_value_i(ov), .in_value_o(iv), .in_reliable_o(rel), .out_send_o(snd),
    .out_sent_value_o(sv), .rtc_o(rtc), .node_status_o(nst), .irq_o(irq));
  nvhb_peer peer (.sys_clk_i(clk), .upd_o(upd), .ts_wr_o(ts_wr), .ts_o(ts_v), .nreq_wr_o(nreq_wr),
    .nreq_o(nreq_v));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) for (int j = 0; j < N_OUT; j++) sc[j] <= sc[j] + int'(snd[j]);

  task test_done();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      err_count++;
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [7:0] nd);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, nd, a, d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [7:0] nd);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, nd, a, 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 ck("rdata", e, rdata);
  endtask
  task ws(input int j, input int lim);
    // Step off the edge: the previous pulse still shows in its time step
    #1;
    n = 0;
    while (snd[j] !== 1'b1) begin
      if (n == lim) begin
        err_count++;
        test_done();
      end
      cyc(1);
      n++;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    bus = '0;
    ov = '0;
    err_count = 0;
    n_tests = 0;
    seed = 32'h95D7AE53;
    node = $random(seed);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(6);
    // ---------------------------------------------------------------
    // Registers, node match, calibration store
    // ---------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      rchk(RW[k], 32'h0, node);
      mdl[RW[k]] = {16'h0, 16'($random(seed))};
      wr(RW[k], mdl[RW[k]], node);
      wr(RW[k], 32'h0000_1234, node + 8'h01);
      rchk(RW[k], mdl[RW[k]], node);
      rchk(RW[k], 32'h0, node ^ 8'h80);
    end
    rchk(A_NODE, {24'h0, node}, node);
    rchk(8'h3C, 32'h0, node);
    wr(A_IN_REL, 32'hF, node);
    rchk(A_IN_REL, 32'h0, node);
    for (int k = 0; k < 2; k++) begin
      cv[k] = $random(seed);
      wr(A_CAL_ADDR, k + 5, node);
      wr(A_CAL_DATA, {16'h0, cv[k]}, node);
    end
    for (int k = 0; k < 2; k++) begin
      wr(A_CAL_ADDR, k + 5, node);
      cyc(2);
      rchk(A_CAL_DATA, {16'h0, cv[k]}, node);
    end
    // ---------------------------------------------------------------
    // Input supervision
    // ---------------------------------------------------------------
    wr(A_RCV_HB, 32'h3, node);
    v = $random(seed);
    peer.src_upd(0, v, 1'b1);
    cyc(1);
    ck("in_value", v, iv[0]);
    ck("reliable", 1, rel[0]);
    cyc(12);
    ck("reliable", 1, rel[0]);
    cyc(26);
    ck("reliable", 0, rel[0]);
    ck("in_value", v, iv[0]);
    ck("nst_unrel", 1, nst[NST_UNREL]);
    peer.src_upd(0, ~v, 1'b1);
    cyc(1);
    ck("reliable", 1, rel[0]);
    wr(A_RCV_HB, 32'h0, node);
    peer.src_upd(1, v, 1'b0);
    cyc(1);
    ck("reliable", 0, rel[1]);
    peer.src_upd(1, v, 1'b1);
    cyc(50);
    ck("reliable", 1, rel[1]);
    ck("nst_unrel", 0, nst[NST_UNREL]);
    // ---------------------------------------------------------------
    // Interrupt and time sync
    // ---------------------------------------------------------------
    wr(A_IRQ_STAT, 32'h7, node);
    wr(A_IRQ_MASK, 32'h7, node);
    t = $random(seed);
    peer.time_sync(t);
    #1 ck("rtc", t, rtc);
    wr(A_RTC, ~t, node);
    #1 ck("rtc_wr", ~t, rtc);
    cyc(3);
    ck("irq", 1, irq);
    rchk(A_IRQ_STAT, 32'h2, node);
    wr(A_IRQ_STAT, 32'h2, node);
    cyc(3);
    ck("irq", 0, irq);
    wr(A_IRQ_MASK, 32'h0, node);
    peer.node_req(8'h07);
    cyc(3);
    ck("irq", 0, irq);
    rchk(A_IRQ_STAT, 32'h4, node);
    // ---------------------------------------------------------------
    // Output sending
    // ---------------------------------------------------------------
    wr(A_MIN_ANA, 32'h2, node);
    wr(A_MIN_DIG, 32'h0, node);
    wr(A_OUT_DIG, 32'h4, node);
    wr(A_SEND_HB, 32'h0, node);
    cyc(30);
    @(posedge clk);
    ov[1] <= $random(seed) | 1;
    ws(1, 5);
    ck("sent", ov[1], sv[1]);
    @(posedge clk);
    ov[1] <= ov[1] ^ 16'h0001;
    ws(1, 40);
    ck("min_gap", 1, n >= 8);
    @(posedge clk);
    ov[2] <= $random(seed) | 1;
    ws(2, 5);
    @(posedge clk);
    ov[2] <= ov[2] + 16'h0001;
    ws(2, 5);
    ck("dig_gap", 1, n <= 2);
    wr(A_MIN_ANA, 32'h0, node);
    wr(A_SEND_HB, 32'h2, node);
    ws(3, 40);
    cyc(1);
    ws(3, 40);
    ck("hb_gap", 1, n >= 8 && n <= 22);
    wr(A_SEND_HB, 32'h0, node);
    // ---------------------------------------------------------------
    // Node requests
    // ---------------------------------------------------------------
    off_m = 1'b0;
    for (int k = 0; k < 4; k++) begin
      peer.node_req(CODES[k]);
      off_m = CODES[k] == NREQ_DISABLE ? 1'b1 : CODES[k] == NREQ_ENABLE ? 1'b0 : off_m;
      cyc(1);
      ck("offline", off_m, nst[NST_OFFLINE]);
    end
    peer.node_req(NREQ_DISABLE);
    cyc(3);
    n = sc[2];
    @(posedge clk);
    ov[2] <= ov[2] + 16'h0001;
    cyc(20);
    ck("quiet", n, sc[2]);
    peer.node_req(NREQ_ENABLE);
    ws(2, 8);
    test_done();
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule // tb_top
